// ---- common/srm_pkg.sv ----
/*
  Package for the host-side controller of a 4096 x 1 static memory.
  Holds widths, pin timing figures and the derived cycle counts.
  Assumes a 10 MHz system clock.
*/
`default_nettype none
package srm_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W = 12;
  localparam int DEPTH = 4096;
  // Longest address / select access time and least cycle time, ns
  localparam int ACCESS_NS = 35;
  // Deselect time beyond which the short select access applies, ns
  localparam int IDLE_LONG_NS = 55;
  // Least write strobe low time, ns
  localparam int WRITE_PULSE_NS = 20;
  localparam int ACCESS_CYC =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_LONG_CYC =
    (IDLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  typedef enum logic [2:0] {
    SRM_IDLE, SRM_RD_SEL, SRM_RD_WAIT, SRM_WR_STROBE, SRM_WR_END
  } srm_state_t;
endpackage : srm_pkg
`default_nettype wire

// ---- rtl/srm_host.sv ----
/*
  Host controller that drives a 4096 x 1 asynchronous static memory by its
  pins: address, active-low select, active-low write strobe, data-in, and
  the three-state data-out. Assumes the memory is wired directly to the
  pins and that data_out from the memory is asynchronous to clk.
*/
// Function
// [R1] The memory holds 4096 one-bit words chosen by twelve address lines.
// [R2] The memory is static and is steered only by pin levels.
// [R3] With select high the memory stands by and wakes with no penalty.
// [R4] A write happens only while select and write strobe are both low.
// [R5] The host holds the write strobe high for the whole of a read.
// [R6] Read data has the polarity written and reading keeps the contents.
// [R7] Data-out is three-state so only the selected part drives it.
// [R8] Data-in and data-out may be tied, relying on release during writes.
// [R9] Data-out floats after select rises and drives only after it falls.
// [R10] Data-out floats while the write strobe is low.
// [R11] Select rising with the write strobe keeps data-out floating.
// [R12] Full select access speed needs more than 55 ns of deselection.
// [R13] The host sets a valid address no later than select falls.
// [R14] Least cycle time equals the longest address access time.
// [R15] With select high the memory ignores strobe and data-in.
`timescale 1ns/1ns
`default_nettype none
module srm_host
  import srm_pkg::*;
#(
  parameter int AW = srm_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic req_wdata,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic [AW-1:0] mem_addr,
  output logic mem_sel_b,
  output logic mem_wr_b,
  output logic mem_din,
  input wire logic mem_dout
);
  import srm_pkg::*;

  srm_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] idle_ff, nxt_idle;
  logic [AW-1:0] addr_ff;
  logic sel_b_ff, wr_b_ff, din_ff, rdata_ff, rvalid_ff;
  logic dout_s1_ff, dout_s2_ff;

  function automatic logic [CNT_W-1:0] cnt_of(input int cyc);
    cnt_of = (cyc < 1) ? CNT_ONE : CNT_W'(cyc);
  endfunction : cnt_of

  wire logic take = req_valid && state_ff == SRM_IDLE;
  wire logic cnt_done = cnt_ff <= CNT_ONE;
  // Short deselect stretches the select access; one extra cycle covers it
  wire logic long_idle = idle_ff >= cnt_of(IDLE_LONG_CYC); // [R12]
  wire logic [CNT_W-1:0] rd_cycles =
    long_idle ? cnt_of(ACCESS_CYC) : cnt_of(ACCESS_CYC) + CNT_ONE; // [R12]

  assign req_ready = state_ff == SRM_IDLE;
  assign mem_addr = addr_ff;
  assign mem_sel_b = sel_b_ff;
  assign mem_wr_b = wr_b_ff;
  assign mem_din = din_ff;
  assign rsp_valid = rvalid_ff;
  assign rsp_rdata = rdata_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_done ? CNT_ZERO : cnt_ff - CNT_ONE;
    nxt_idle = (sel_b_ff && idle_ff != '1) ? idle_ff + CNT_ONE : idle_ff;
    case (state_ff)
      SRM_IDLE: begin
        if (take) begin
          // Read address is set one cycle before select falls; a write sets it on the edge select falls
          nxt_state = req_write ? SRM_WR_STROBE : SRM_RD_SEL; // [R13]
          nxt_cnt = req_write ? cnt_of(WRITE_PULSE_CYC) : rd_cycles;
        end
      end
      SRM_RD_SEL: begin
        nxt_state = SRM_RD_WAIT;
        nxt_idle = CNT_ZERO;
        // Count held so the extra short-idle cycle is not lost here
        nxt_cnt = cnt_ff; // [R12]
      end
      SRM_RD_WAIT: begin
        // Waits one cycle, or two after a short deselect; the synchroniser lag is taken after the read ends
        if (cnt_done) begin
          nxt_state = SRM_IDLE; // [R14]
        end
      end
      SRM_WR_STROBE: begin
        nxt_idle = CNT_ZERO;
        if (cnt_done) begin
          nxt_state = SRM_WR_END;
        end
      end
      SRM_WR_END: nxt_state = SRM_IDLE;
      default: nxt_state = SRM_IDLE;
    endcase
  end

  // Read wait: select low, strobe high, wait access then sample late copy
  logic [1:0] rd_lag_ff;
  logic [1:0] nxt_rd_lag;
  wire logic rd_last = state_ff == SRM_RD_WAIT && cnt_done;
  wire logic nxt_sel_low = nxt_state == SRM_RD_WAIT
                           || nxt_state == SRM_WR_STROBE;
  wire logic nxt_wr_low = nxt_state == SRM_WR_STROBE;

  assign nxt_rd_lag = {rd_lag_ff[0], rd_last};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= SRM_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= CNT_ZERO;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Saturates so a long standby still reads as long
  // Idle is judged at take time, so the choice errs on the slow side
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      idle_ff <= '1;
    end else if (ce) begin
      idle_ff <= nxt_idle; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_ff <= '0;
    end else if (ce && take) begin
      addr_ff <= req_addr; // [R1] [R13]
    end
  end

  // Data-in is held through the whole strobe, past its rising edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      din_ff <= 1'b0;
    end else if (ce && take) begin
      din_ff <= req_wdata; // [R4] [R15]
    end
  end

  // Select and strobe are both low only across a write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_b_ff <= 1'b1;
    end else if (ce) begin
      sel_b_ff <= !nxt_sel_low; // [R2] [R3] [R4]
    end
  end

  // Strobe high for every read; it rises with select, ending the write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_b_ff <= 1'b1;
    end else if (ce) begin
      wr_b_ff <= !nxt_wr_low; // [R4] [R5] [R10] [R11] [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dout_s1_ff <= 1'b0;
    end else if (ce) begin
      dout_s1_ff <= mem_dout;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dout_s2_ff <= 1'b0;
    end else if (ce) begin
      dout_s2_ff <= dout_s1_ff;
    end
  end

  // Data is sampled two cycles after the read ends to match the sync lag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_lag_ff <= 2'h0;
    end else if (ce) begin
      rd_lag_ff <= nxt_rd_lag;
    end
  end

  // Answer pulses once per read, never from a write's float
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rvalid_ff <= rd_lag_ff[1]; // [R10]
    end
  end

  // Holds the last read until the next one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_ff <= 1'b0;
    end else if (ce && rd_lag_ff[1]) begin
      rdata_ff <= dout_s2_ff; // [R6] [R7] [R9]
    end
  end
endmodule : srm_host
`default_nettype wire

// ---- verif/srm_mem_model.sv ----
/* 4096 x 1 static memory model.
   Pins come straight from srm_host. */
`timescale 1ns/1ns
`default_nettype none
module srm_mem_model (
  input wire logic [11:0] addr,
  input wire logic sel_b,
  input wire logic wr_b,
  input wire logic din,
  output logic dout
);
  logic mem_ff [4096];
  // Released output shows the inverse, so a late sample cannot pass
  assign dout = (!sel_b && wr_b) ? mem_ff[addr] : ~mem_ff[addr];
  always @* if (!sel_b && !wr_b) mem_ff[addr] = din;
endmodule : srm_mem_model
`default_nettype wire

// ---- verif/srm_host_monitor.sv ----
/* Pin checker for srm_host.
   Sees only its ports; bound after the module. */
`timescale 1ns/1ns
`default_nettype none
module srm_host_monitor #(parameter int AW = 12) (
  input wire logic clk, rst_b, ce, req_valid, req_ready, req_write,
  input wire logic [AW-1:0] req_addr, mem_addr,
  input wire logic req_wdata, rsp_valid, mem_sel_b, mem_wr_b, mem_din
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk, rd_tk, wr_tk;
  assign tk = ce && req_valid && req_ready;
  assign rd_tk = tk && !req_write;
  assign wr_tk = tk && req_write;
  wr_pulse_a:
  assert property (wr_tk |=> !mem_sel_b && !mem_wr_b ##1 mem_sel_b
    && mem_wr_b) else $error("write pulse");
  wr_pins_a:
  assert property (wr_tk |=> mem_din == $past(req_wdata) &&
    mem_addr == $past(req_addr)) else $error("write pins");
  rd_sel_a:
  assert property (rd_tk |=> mem_sel_b && mem_addr == $past(req_addr)
    ##1 !mem_sel_b && $stable(mem_addr)) else $error("read select");
  rd_strobe_a:
  assert property (rd_tk |=> mem_wr_b [*3]) else $error("read strobe");
  rsp_time_a:
  assert property (rd_tk |-> ##[5:6] rsp_valid) else $error("answer");
  busy_span_a:
  assert property (tk |=> !req_ready [*2] ##[1:2] req_ready)
    else $error("busy");
  rsp_pulse_a:
  assert property (rsp_valid |=> !rsp_valid) else $error("rsp pulse");
  strobe_sel_a:
  assert property (!mem_wr_b |-> !mem_sel_b) else $error("lone strobe");
endmodule : srm_host_monitor
bind srm_host srm_host_monitor #(.AW(AW)) srm_host_monitor_i (.*);
`default_nettype wire

// ---- verif/srm_host_tb_top.sv ----
/* Bench for srm_host with the memory model.
   One clock, fixed stimulus. */
`timescale 1ns/1ns
`default_nettype none
module srm_host_tb_top;
  import srm_pkg::*;
  logic clk = 0, rst_b = 0, req_valid = 0, req_write = 0, req_wdata = 0;
  logic req_ready, rsp_valid, rsp_rdata, mem_sel_b, mem_wr_b, mem_din, dq;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  int err_total = 0, n_tests = 0, cyc = 0;
  always #50 clk = ~clk;
  srm_host srm_host_i (.clk, .rst_b, .ce(1'b1), .req_valid, .req_ready,
    .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .mem_addr,
    .mem_sel_b, .mem_wr_b, .mem_din, .mem_dout(dq));
  srm_mem_model srm_mem_model_i (.addr(mem_addr), .sel_b(mem_sel_b),
    .wr_b(mem_wr_b), .din(mem_din), .dout(dq));
  task automatic chk(input logic s, input logic e, input string n);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %b seen %b", n, e, s);
    end
  endtask : chk
  task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic d);
    @(posedge clk);
    {req_valid, req_write, req_addr, req_wdata} <= {1'b1, w, a, d};
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask : op
  task automatic rsp_wait(output int n);
    n = 0;
    while (n < 9 && rsp_valid !== 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask : rsp_wait
  task automatic rd(input logic [ADDR_W-1:0] a, input logic e);
    int n;
    op(1'b0, a, 1'b0);
    rsp_wait(n);
    chk(rsp_valid, 1'b1, "rsp_valid");
    chk(rsp_rdata, e, "rsp_rdata");
  endtask : rd
  task automatic t_bounds;
    op(1'b1, 12'h000, 1'b0);
    op(1'b1, 12'hfff, 1'b1);
    op(1'b1, 12'h800, 1'b1);
    rd(12'h000, 1'b0);
    rd(12'hfff, 1'b1);
    rd(12'h800, 1'b1);
    $display("t_bounds done");
  endtask : t_bounds
  task automatic t_reread;
    op(1'b1, 12'h5a5, 1'b1);
    rd(12'h5a5, 1'b1);
    rd(12'h5a5, 1'b1);
    op(1'b1, 12'h5a5, 1'b0);
    rd(12'h5a5, 1'b0);
    $display("t_reread done");
  endtask : t_reread
  task automatic t_mixed;
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 12'h0f0 + 12'(i), i[0]);
      rd(12'h0f0 + 12'(i), i[0]);
    end
    $display("t_mixed done");
  endtask : t_mixed
  // Second read taken on the first ready edge, after a short deselect
  task automatic t_b2b;
    int n;
    @(posedge clk);
    {req_valid, req_write, req_addr} <= {1'b1, 1'b0, 12'h5a5};
    do @(posedge clk); while (req_ready !== 1'b1);
    req_addr <= 12'h0f1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    rsp_wait(n);
    chk(rsp_valid, 1'b1, "b2b first valid");
    chk(rsp_rdata, 1'b0, "b2b first data");
    @(negedge clk);
    rsp_wait(n);
    chk(rsp_valid, 1'b1, "b2b second valid");
    chk(n == 3, 1'b1, "short idle gap");
    chk(rsp_rdata, 1'b1, "b2b second data");
    $display("t_b2b done");
  endtask : t_b2b
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_bounds();
    t_reread();
    t_mixed();
    t_b2b();
    end_sim();
  end
endmodule : srm_host_tb_top
`default_nettype wire
